/* rtl/npch_handler.sv */
// password change and protection enable/disable command handler
//
// Functional notes
// - class 00 ins 24 replaces read or write password of selected file
// - password change carries length byte 10h and sixteen data bytes
// - password change without password data answers an error status
// - command runs only with satisfied security, else status 6982
// - change reports 9000, 6581, 6981, 6A80 as the case may be
// - class 00 ins 28 switches on password protection of the file
// - enable has no length, data or expected length; parameter selects
// - low five parameter bits identify the verified password
// - enable answers about 5 ms after the command when committing
// - enable reports 9000, 6981, 6A80, 6A82, 6A86 as the case may be
// - class 00 ins 26 removes protection from read or write access
// - disable answers about 6 ms after the command when committing
// - disable answers 6A80 on cc or system file, 6581 on failure
// - successful verify grants access for the whole selected file
// - three password checks per session, remaining count in status
`timescale 1ns/10ps
module npch_handler #(
   parameter int unsigned EN_DELAY  = npch_pkg::EN_CYCLES,
   parameter int unsigned DIS_DELAY = npch_pkg::DIS_CYCLES,
   parameter int unsigned CHG_DELAY = npch_pkg::CHG_CYCLES
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   input  wire logic         cmd_valid_i,
   input  wire logic [7:0]   cmd_byte_i,
   input  wire logic         cmd_last_i,
   output logic              cmd_ready_o,
   output logic              rsp_valid_o,
   output logic [15:0]       rsp_sw_o,
   input  wire logic         rsp_ready_i,
   input  wire logic         session_end_i,
   input  wire logic [1:0]   file_sel_i,
   input  wire logic         verify_pass_i,
   input  wire logic         verify_fail_i,
   output logic [15:0]       retry_sw_o,
   output logic              wr_granted_o,
   input  wire logic         pwd_rd_wr_i,
   output logic [127:0]      pwd_rd_data_o,
   input  wire logic         eeprom_fail_i,
   output logic              rd_prot_o,
   output logic              wr_prot_o,
   output logic              busy_o
);

   typedef enum logic [1:0] {ST_RX, ST_CHECK, ST_BUSY, ST_RESP} npch_state_type;

   npch_state_type state_r;
   logic [7:0]     cla_r, ins_r, p1_r, p2_r, lc_r;
   logic [4:0]     idx_r;
   logic           ovf_r;
   logic [127:0]   buf_r;
   logic [npch_pkg::DLY_W-1:0] dly_r;
   logic [15:0]    chk_sw;
   logic           ours;
   logic           sel_wr;
   logic           wr_ver_r;
   logic [1:0]     retries_r;
   logic [1:0]     file_prev_r;
   logic           rd_prot_r, wr_prot_r;
   logic           commit;

   npch_store_if st ();

   npch_pwd_store u_store (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .st    (st.mem)
   );

   // ---------------------------------------------------------------
   // shared front checks: parameter, file presence, file type
   // ---------------------------------------------------------------
   function automatic logic [15:0] front_check(input logic [7:0] p1,
                                               input logic [7:0] p2,
                                               input logic [1:0] file,
                                               input logic [15:0] wrong_file);
      logic [4:0] id;
      id = p2[npch_pkg::PWD_ID_LSB +: 5];
      if (p1 != npch_pkg::P1_NONE ||
          (id != npch_pkg::PWD_ID_READ && id != npch_pkg::PWD_ID_WRITE)) begin
         front_check = npch_pkg::SW_BAD_P1P2;
      end else if (file == npch_pkg::FILE_NONE) begin
         front_check = npch_pkg::SW_NOT_FOUND;
      end else if (file != npch_pkg::FILE_NDEF) begin
         front_check = wrong_file;
      end else begin
         front_check = npch_pkg::SW_OK;
      end
   endfunction

   assign sel_wr = (p2_r[npch_pkg::PWD_ID_LSB +: 5] == npch_pkg::PWD_ID_WRITE);
   assign ours   = (cla_r == npch_pkg::CLA_ISO) && (idx_r >= npch_pkg::HDR_BYTES) &&
                   (ins_r == npch_pkg::INS_CHANGE || ins_r == npch_pkg::INS_ENABLE ||
                    ins_r == npch_pkg::INS_DISABLE);

   // ---------------------------------------------------------------
   // status decision for the frame just received
   // ---------------------------------------------------------------
   always_comb begin
      chk_sw = npch_pkg::SW_OK;
      case (ins_r)
         npch_pkg::INS_CHANGE: begin
            chk_sw = front_check(p1_r, p2_r, file_sel_i, npch_pkg::SW_FILE_STRUCT);
            if (chk_sw == npch_pkg::SW_OK) begin
               if (ovf_r || idx_r != npch_pkg::FRAME_PWD || lc_r != npch_pkg::LC_PWD) begin
                  chk_sw = npch_pkg::SW_BAD_DATA;
               end else if (!wr_ver_r) begin
                  chk_sw = npch_pkg::SW_SECURITY;
               end
            end
         end
         npch_pkg::INS_ENABLE: begin
            chk_sw = front_check(p1_r, p2_r, file_sel_i, npch_pkg::SW_FILE_STRUCT);
            if (chk_sw == npch_pkg::SW_OK) begin
               if (ovf_r || idx_r != npch_pkg::HDR_BYTES) begin
                  chk_sw = npch_pkg::SW_BAD_DATA;
               end else if (!wr_ver_r) begin
                  chk_sw = npch_pkg::SW_SECURITY;
               end
            end
         end
         default: begin
            chk_sw = front_check(p1_r, p2_r, file_sel_i, npch_pkg::SW_BAD_DATA);
            if (chk_sw == npch_pkg::SW_OK) begin
               if (ovf_r || idx_r != npch_pkg::HDR_BYTES) begin
                  chk_sw = npch_pkg::SW_BAD_DATA;
               end else if (!wr_ver_r) begin
                  chk_sw = npch_pkg::SW_SECURITY;
               end
            end
         end
      endcase
   end

   assign commit = (state_r == ST_BUSY) && (dly_r == '0) && !eeprom_fail_i;

   // ---------------------------------------------------------------
   // command sequencer: receive, check, commit, answer
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r  <= ST_RX;
         dly_r    <= '0;
         rsp_sw_o <= npch_pkg::SW_OK;
      end else if (ce_i) begin
         case (state_r)
            ST_RX: begin
               if (cmd_valid_i && cmd_last_i) begin
                  state_r <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               if (!ours) begin
                  state_r <= ST_RX; // frames for other handlers pass silently
               end else if (chk_sw != npch_pkg::SW_OK) begin
                  rsp_sw_o <= chk_sw;
                  state_r  <= ST_RESP;
               end else begin
                  state_r <= ST_BUSY;
                  if (ins_r == npch_pkg::INS_ENABLE) begin
                     dly_r <= npch_pkg::DLY_W'(EN_DELAY - 1);
                  end else if (ins_r == npch_pkg::INS_DISABLE) begin
                     dly_r <= npch_pkg::DLY_W'(DIS_DELAY - 1);
                  end else begin
                     dly_r <= npch_pkg::DLY_W'(CHG_DELAY - 1);
                  end
               end
            end
            ST_BUSY: begin
               if (dly_r != '0) begin
                  dly_r <= dly_r - 1'b1;
               end else begin
                  rsp_sw_o <= eeprom_fail_i ? npch_pkg::SW_UPD_FAIL : npch_pkg::SW_OK;
                  state_r  <= ST_RESP;
               end
            end
            ST_RESP: begin
               if (rsp_ready_i) begin
                  state_r <= ST_RX;
               end
            end
            default: state_r <= ST_RX;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // frame capture; bytes past the password are flagged and still shifted into the buffer
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         idx_r <= '0;
         ovf_r <= 1'b0;
         cla_r <= 8'h00;
         ins_r <= 8'h00;
         p1_r  <= 8'h00;
         p2_r  <= 8'h00;
         lc_r  <= 8'h00;
         buf_r <= npch_pkg::PWD_RST;
      end else if (ce_i) begin
         if (state_r == ST_RESP || (state_r == ST_CHECK && !ours)) begin
            idx_r <= '0;
            ovf_r <= 1'b0;
            lc_r  <= 8'h00;
         end else if (state_r == ST_RX && cmd_valid_i) begin
            case (idx_r)
               5'h00:   cla_r <= cmd_byte_i;
               5'h01:   ins_r <= cmd_byte_i;
               5'h02:   p1_r  <= cmd_byte_i;
               5'h03:   p2_r  <= cmd_byte_i;
               5'h04:   lc_r  <= cmd_byte_i;
               default: buf_r <= {buf_r[119:0], cmd_byte_i}; // first byte ends up msb
            endcase
            if (idx_r == npch_pkg::FRAME_PWD) begin
               ovf_r <= 1'b1;
            end else begin
               idx_r <= idx_r + 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // session security: write grant and retry budget
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ver_r    <= 1'b0;
         retries_r   <= npch_pkg::RETRY_MAX;
         file_prev_r <= npch_pkg::FILE_NONE;
      end else if (ce_i) begin
         file_prev_r <= file_sel_i;
         if (session_end_i) begin
            wr_ver_r  <= 1'b0;
            retries_r <= npch_pkg::RETRY_MAX;
         end else begin
            // a failed check costs a retry while any remain, file change or not
            if (verify_fail_i && retries_r != 2'h0) retries_r <= retries_r - 1'b1;
            if (file_sel_i != file_prev_r) wr_ver_r <= 1'b0;
            else if (verify_pass_i && retries_r != 2'h0) wr_ver_r <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // protection flags, changed only when the commit succeeds
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_prot_r <= npch_pkg::RD_PROT_RST;
         wr_prot_r <= npch_pkg::WR_PROT_RST;
      end else if (ce_i && commit) begin
         if (ins_r == npch_pkg::INS_ENABLE) begin
            if (sel_wr) wr_prot_r <= 1'b1;
            else rd_prot_r <= 1'b1;
         end else if (ins_r == npch_pkg::INS_DISABLE) begin
            if (sel_wr) wr_prot_r <= 1'b0;
            else rd_prot_r <= 1'b0;
         end
      end
   end

   // password write happens on the same commit edge as the status update
   assign st.we      = ce_i && commit && (ins_r == npch_pkg::INS_CHANGE);
   assign st.wsel_wr = sel_wr;
   assign st.wdata   = buf_r;
   assign st.rsel_wr = pwd_rd_wr_i;

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign cmd_ready_o   = (state_r == ST_RX);
   assign rsp_valid_o   = (state_r == ST_RESP);
   assign busy_o        = (state_r == ST_BUSY);
   assign retry_sw_o    = npch_pkg::SW_RETRY_BASE | {14'h0000, retries_r};
   assign wr_granted_o  = wr_ver_r;
   assign pwd_rd_data_o = st.rdata;
   assign rd_prot_o     = rd_prot_r;
   assign wr_prot_o     = wr_prot_r;

endmodule

/* rtl/npch_pkg.sv */
// constants shared by the password command handler and its password store
package npch_pkg;

   // ---------------------------------------------------------------
   // command header codes
   // ---------------------------------------------------------------
   localparam logic [7:0] CLA_ISO     = 8'h00;
   localparam logic [7:0] INS_CHANGE  = 8'h24;
   localparam logic [7:0] INS_ENABLE  = 8'h28;
   localparam logic [7:0] INS_DISABLE = 8'h26;
   localparam logic [7:0] LC_PWD      = 8'h10;
   localparam logic [7:0] P1_NONE     = 8'h00;

   // low five bits of the parameter field name the password
   localparam logic [4:0] PWD_ID_READ  = 5'h01;
   localparam logic [4:0] PWD_ID_WRITE = 5'h02;
   localparam int         PWD_ID_LSB   = 0;

   // ---------------------------------------------------------------
   // status words
   // ---------------------------------------------------------------
   localparam logic [15:0] SW_OK          = 16'h9000;
   localparam logic [15:0] SW_UPD_FAIL    = 16'h6581;
   localparam logic [15:0] SW_FILE_STRUCT = 16'h6981;
   localparam logic [15:0] SW_SECURITY    = 16'h6982;
   localparam logic [15:0] SW_BAD_DATA    = 16'h6A80;
   localparam logic [15:0] SW_NOT_FOUND   = 16'h6A82;
   localparam logic [15:0] SW_BAD_P1P2    = 16'h6A86;
   localparam logic [15:0] SW_RETRY_BASE  = 16'h63C0;

   // ---------------------------------------------------------------
   // selected file codes
   // ---------------------------------------------------------------
   localparam logic [1:0] FILE_NONE = 2'h0;
   localparam logic [1:0] FILE_CC   = 2'h1;
   localparam logic [1:0] FILE_NDEF = 2'h2;
   localparam logic [1:0] FILE_SYS  = 2'h3;

   // ---------------------------------------------------------------
   // frame layout and counts
   // ---------------------------------------------------------------
   localparam logic [4:0] HDR_BYTES    = 5'h04;
   localparam logic [4:0] FRAME_PWD    = 5'h15;
   localparam logic [1:0] RETRY_MAX    = 2'h3;
   localparam int         PWD_BITS     = 128;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic           RD_PROT_RST = 1'b0;
   localparam logic           WR_PROT_RST = 1'b0;
   localparam logic [127:0]   PWD_RST     = {8{16'h0000}};

   // ---------------------------------------------------------------
   // commit times and their cycle counts
   // ---------------------------------------------------------------
   localparam int CLK_MHZ     = 250;
   localparam int EN_TIME_US  = 5000;
   localparam int DIS_TIME_US = 6000;
   localparam int CHG_TIME_US = 6000;
   localparam int EN_CYCLES   = EN_TIME_US * CLK_MHZ;
   localparam int DIS_CYCLES  = DIS_TIME_US * CLK_MHZ;
   localparam int CHG_CYCLES  = CHG_TIME_US * CLK_MHZ;
   localparam int DLY_W       = 21;

endpackage

/* rtl/npch_pwd_store.sv */
// storage of the read and write passwords with registered read data
`timescale 1ns/10ps
module npch_pwd_store (
   input  wire logic   clk_i,
   input  wire logic   rst_i,
   input  wire logic   ce_i,
   npch_store_if.mem   st
);

   logic [127:0] pwd_r [2];

   // ---------------------------------------------------------------
   // write port: index 1 holds the write password
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pwd_r[0] <= npch_pkg::PWD_RST;
         pwd_r[1] <= npch_pkg::PWD_RST;
      end else if (ce_i && st.we) begin
         pwd_r[st.wsel_wr] <= st.wdata;
      end
   end

   // read data registered so the compare path outside sees a clean flop
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st.rdata <= npch_pkg::PWD_RST;
      end else if (ce_i) begin
         st.rdata <= pwd_r[st.rsel_wr];
      end
   end

endmodule

/* rtl/npch_store_if.sv */
// carrier between the command handler and its password store
`timescale 1ns/10ps
interface npch_store_if;
   logic         we;
   logic         wsel_wr;
   logic [127:0] wdata;
   logic         rsel_wr;
   logic [127:0] rdata;

   modport ctl (output we, output wsel_wr, output wdata, output rsel_wr, input rdata);
   modport mem (input we, input wsel_wr, input wdata, input rsel_wr, output rdata);
endinterface

/* testbench/npch_handler_assertions.sv */
// concurrent checks on the ports of the password command handler
`timescale 1ns/10ps
module npch_handler_assertions #(
   parameter int unsigned EN_DELAY  = 5,
   parameter int unsigned DIS_DELAY = 6,
   parameter int unsigned CHG_DELAY = 7
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   input wire logic        rsp_ready_i,
   input wire logic        session_end_i,
   input wire logic [1:0]  file_sel_i,
   input wire logic        verify_fail_i,
   input wire logic        cmd_ready_o,
   input wire logic        rsp_valid_o,
   input wire logic [15:0] rsp_sw_o,
   input wire logic [15:0] retry_sw_o,
   input wire logic        wr_granted_o,
   input wire logic        rd_prot_o,
   input wire logic        wr_prot_o,
   input wire logic        busy_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic [31:0] busy_cnt_r;

   // length of the current commit wait; frozen cycles do not count
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_cnt_r <= 32'h0000_0000;
      end else if (!busy_o) begin
         busy_cnt_r <= 32'h0000_0000;
      end else if (ce_i) begin
         busy_cnt_r <= busy_cnt_r + 32'h0000_0001;
      end
   end

   AST_SW_HOLD: assert property (rsp_valid_o && !rsp_ready_i
      |=> rsp_valid_o && $stable(rsp_sw_o))
      else $error("status word dropped before acceptance");
   AST_NO_RX_IN_RSP: assert property (rsp_valid_o |-> !cmd_ready_o && !busy_o)
      else $error("command port open while answering");
   AST_READY_AFTER: assert property (ce_i && rsp_valid_o && rsp_ready_i
      |=> cmd_ready_o && !rsp_valid_o)
      else $error("port not reopened after acceptance");
   AST_COMMIT_LEN: assert property ($fell(busy_o) |-> rsp_valid_o &&
      (busy_cnt_r == EN_DELAY || busy_cnt_r == DIS_DELAY || busy_cnt_r == CHG_DELAY))
      else $error("commit wait has wrong length");
   AST_ERR_NO_WAIT: assert property ($rose(rsp_valid_o) && !$past(busy_o)
      |-> rsp_sw_o != 16'h9000)
      else $error("success answered without commit wait");
   AST_SEC_GRANT: assert property ($rose(busy_o) |-> $past(wr_granted_o))
      else $error("commit started without write grant");
   AST_PROT_ONLY_OK: assert property ($changed(rd_prot_o) || $changed(wr_prot_o)
      |-> rsp_valid_o && rsp_sw_o == 16'h9000)
      else $error("protection changed without success");
   AST_RETRY_DEC: assert property (ce_i && verify_fail_i && !session_end_i
      && retry_sw_o[1:0] != 2'h0 |=> retry_sw_o[1:0] == $past(retry_sw_o[1:0]) - 2'h1)
      else $error("retry count not decremented");
   AST_SESSION: assert property (ce_i && session_end_i
      |=> !wr_granted_o && retry_sw_o == 16'h63C3)
      else $error("session end did not clear state");
   AST_FILE_CLR: assert property ($changed(file_sel_i) |-> ##[1:2] !wr_granted_o)
      else $error("grant kept across file change");

   COV_COMMIT: cover property ($fell(busy_o));
   COV_SECURITY: cover property (rsp_valid_o && rsp_sw_o == 16'h6982);
   COV_NO_RETRY: cover property (verify_fail_i && retry_sw_o[1:0] == 2'h0);
endmodule

bind npch_handler npch_handler_assertions #(.EN_DELAY(EN_DELAY), .DIS_DELAY(DIS_DELAY),
   .CHG_DELAY(CHG_DELAY)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .rsp_ready_i(rsp_ready_i), .session_end_i(session_end_i), .file_sel_i(file_sel_i),
   .verify_fail_i(verify_fail_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
   .rsp_sw_o(rsp_sw_o), .retry_sw_o(retry_sw_o), .wr_granted_o(wr_granted_o),
   .rd_prot_o(rd_prot_o), .wr_prot_o(wr_prot_o), .busy_o(busy_o));

/* testbench/npch_host_model.sv */
// reader host model: sends command frames, verifies, accepts status words
`timescale 1ns/10ps
module npch_host_model (
   input wire logic        clk_i,
   input wire logic        cmd_ready_i,
   input wire logic        rsp_valid_i,
   input wire logic [15:0] rsp_sw_i,
   input wire logic        busy_i,
   output logic            cmd_valid_o,
   output logic [7:0]      cmd_byte_o,
   output logic            cmd_last_o,
   output logic            rsp_ready_o,
   output logic            verify_pass_o,
   output logic            verify_fail_o
);
   // idle values at time zero
   initial begin
      cmd_valid_o = 1'b0;
      cmd_byte_o = 8'h00;
      cmd_last_o = 1'b0;
      rsp_ready_o = 1'b0;
      verify_pass_o = 1'b0;
      verify_fail_o = 1'b0;
   end

   // one byte per taken edge; lane shows the inverse once released, so stale data never matches
   task automatic send_frame(input logic [7:0] fr [21], input int len);
      for (int i = 0; i < len; i++) begin
         cmd_valid_o = 1'b1;
         cmd_byte_o = fr[i];
         cmd_last_o = (i == len - 1);
         while (cmd_ready_i !== 1'b1) begin
            @(posedge clk_i);
            #1;
         end
         @(posedge clk_i);
         #1;
      end
      cmd_valid_o = 1'b0;
      cmd_last_o = 1'b0;
      cmd_byte_o = ~cmd_byte_o;
   endtask

   // wait for the answer, stall a while, then accept it on one edge
   task automatic get_rsp(input int stall, output logic [15:0] sw, output int busy_n);
      busy_n = 0;
      while (rsp_valid_i !== 1'b1) begin
         if (busy_i === 1'b1) busy_n++;
         @(posedge clk_i);
         #1;
      end
      repeat (stall) begin
         @(posedge clk_i);
         #1;
      end
      rsp_ready_o = 1'b1;
      sw = rsp_sw_i;
      @(posedge clk_i);
      #1;
      rsp_ready_o = 1'b0;
   endtask

   // outcome of a verify with the write password, one cycle pulse
   task automatic verify(input logic ok);
      verify_pass_o = ok;
      verify_fail_o = !ok;
      @(posedge clk_i);
      #1;
      verify_pass_o = 1'b0;
      verify_fail_o = 1'b0;
   endtask
endmodule

/* testbench/tb.sv */
// self-checking bench for the password command handler
`timescale 1ns/10ps
module tb;
   localparam int unsigned EN_D = 5;
   localparam int unsigned DIS_D = 6;
   localparam int unsigned CHG_D = 7;
   logic clk_i, rst_i, ce_i, cmd_valid, cmd_last, cmd_ready, rsp_valid, rsp_ready;
   logic session_end, verify_pass, verify_fail, wr_granted, pwd_rd_wr, eeprom_fail;
   logic rd_prot, wr_prot, busy;
   logic [7:0]   cmd_byte;
   logic [15:0]  rsp_sw, retry_sw, sw;
   logic [1:0]   file_sel;
   logic [127:0] pwd_rd_data, exp_pwd;
   logic [7:0]   fr [21];
   int failures, total_checks, cycles, busy_n;

   npch_handler #(.EN_DELAY(EN_D), .DIS_DELAY(DIS_D), .CHG_DELAY(CHG_D)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cmd_valid_i(cmd_valid),
      .cmd_byte_i(cmd_byte), .cmd_last_i(cmd_last), .cmd_ready_o(cmd_ready),
      .rsp_valid_o(rsp_valid), .rsp_sw_o(rsp_sw), .rsp_ready_i(rsp_ready),
      .session_end_i(session_end), .file_sel_i(file_sel), .verify_pass_i(verify_pass),
      .verify_fail_i(verify_fail), .retry_sw_o(retry_sw), .wr_granted_o(wr_granted),
      .pwd_rd_wr_i(pwd_rd_wr), .pwd_rd_data_o(pwd_rd_data), .eeprom_fail_i(eeprom_fail),
      .rd_prot_o(rd_prot), .wr_prot_o(wr_prot), .busy_o(busy));
   npch_host_model u_host (.clk_i(clk_i), .cmd_ready_i(cmd_ready), .rsp_valid_i(rsp_valid),
      .rsp_sw_i(rsp_sw), .busy_i(busy), .cmd_valid_o(cmd_valid), .cmd_byte_o(cmd_byte),
      .cmd_last_o(cmd_last), .rsp_ready_o(rsp_ready), .verify_pass_o(verify_pass),
      .verify_fail_o(verify_fail));

   // 250 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // hang guard: the whole run needs well under this many cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 6000) begin
         failures++;
         end_of_test();
      end
   end

   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic run(input logic [7:0] ins, input logic [7:0] p1, input logic [7:0] p2,
                      input int len, input int stall);
      fr[0] = npch_pkg::CLA_ISO;
      fr[1] = ins;
      fr[2] = p1;
      fr[3] = p2;
      u_host.send_frame(fr, len);
      u_host.get_rsp(stall, sw, busy_n);
   endtask

   // select a file, send one frame, check the status word of the answer
   task automatic err(input logic [7:0] ins, input logic [7:0] p1, input logic [7:0] p2,
                      input int len, input logic [1:0] file, input logic [15:0] exp);
      file_sel = file;
      @(posedge clk_i);
      #1;
      run(ins, p1, p2, len, 1);
      check(sw, exp);
   endtask

   task automatic t_reset();
      check({rsp_sw, retry_sw}, {npch_pkg::SW_OK, 16'h63C3});
      check({rd_prot, wr_prot, wr_granted, busy, cmd_ready}, 5'h01);
   endtask

   task automatic t_security();
      err(npch_pkg::INS_ENABLE, 8'h00, 8'h01, 4, 2'h2, npch_pkg::SW_SECURITY);
      check({busy_n, rd_prot}, 33'h0_0000_0000);
      ce_i = 1'b0; // a frozen block must not see the verify pulse
      u_host.verify(1'b1);
      check(wr_granted, 1'b0);
      ce_i = 1'b1;
   endtask

   task automatic t_enable_disable();
      u_host.verify(1'b1);
      check(wr_granted, 1'b1);
      for (int i = 0; i < 2; i++) begin
         run(npch_pkg::INS_ENABLE, 8'h00, i ? 8'h02 : 8'hE1, 4, i);
         check(sw, npch_pkg::SW_OK);
         check(busy_n, EN_D);
         check({rd_prot, wr_prot}, i ? 2'h3 : 2'h2);
      end
      for (int i = 0; i < 2; i++) begin
         run(npch_pkg::INS_DISABLE, 8'h00, i ? 8'h02 : 8'h01, 4, 0);
         check(sw, npch_pkg::SW_OK);
         check(busy_n, DIS_D);
         check({rd_prot, wr_prot}, i ? 2'h0 : 2'h1);
      end
   endtask

   task automatic t_change();
      for (int i = 0; i < 2; i++) begin
         fr[4] = npch_pkg::LC_PWD;
         for (int b = 0; b < 16; b++) fr[5 + b] = 8'(8'hA0 + 16 * i + b);
         run(npch_pkg::INS_CHANGE, 8'h00, i ? 8'h02 : 8'h01, 21, 0);
         check(sw, npch_pkg::SW_OK);
         check(busy_n, CHG_D);
         pwd_rd_wr = i[0];
         for (int b = 0; b < 16; b++) exp_pwd[127 - 8 * b -: 8] = fr[5 + b];
         @(posedge clk_i);
         @(posedge clk_i);
         #1;
         check(pwd_rd_data, exp_pwd);
      end
   endtask

   task automatic t_errors();
      fr[4] = 8'h00;
      err(npch_pkg::INS_CHANGE, 8'h00, 8'h01, 5, 2'h2, npch_pkg::SW_BAD_DATA);
      err(npch_pkg::INS_ENABLE, 8'h00, 8'h03, 4, 2'h2, npch_pkg::SW_BAD_P1P2);
      err(npch_pkg::INS_DISABLE, 8'h01, 8'h01, 4, 2'h2, npch_pkg::SW_BAD_P1P2);
      err(npch_pkg::INS_ENABLE, 8'h00, 8'h01, 5, 2'h2, npch_pkg::SW_BAD_DATA);
      err(npch_pkg::INS_ENABLE, 8'h00, 8'h01, 4, 2'h1, npch_pkg::SW_FILE_STRUCT);
      err(npch_pkg::INS_DISABLE, 8'h00, 8'h01, 4, 2'h3, npch_pkg::SW_BAD_DATA);
      err(npch_pkg::INS_CHANGE, 8'h00, 8'h01, 21, 2'h1, npch_pkg::SW_FILE_STRUCT);
      err(npch_pkg::INS_ENABLE, 8'h00, 8'h01, 4, 2'h0, npch_pkg::SW_NOT_FOUND);
      err(npch_pkg::INS_ENABLE, 8'h00, 8'h01, 4, 2'h2, npch_pkg::SW_SECURITY);
      u_host.verify(1'b1);
      eeprom_fail = 1'b1;
      fr[4] = npch_pkg::LC_PWD;
      err(npch_pkg::INS_CHANGE, 8'h00, 8'h01, 21, 2'h2, npch_pkg::SW_UPD_FAIL);
      err(npch_pkg::INS_ENABLE, 8'h00, 8'h02, 4, 2'h2, npch_pkg::SW_UPD_FAIL);
      eeprom_fail = 1'b0;
      check({rd_prot, wr_prot}, 2'h0);
   endtask

   task automatic t_retry();
      session_end = 1'b1; // drop the grant left over from the error scenarios
      @(posedge clk_i);
      #1;
      session_end = 1'b0;
      for (int i = 0; i < 4; i++) begin
         u_host.verify(1'b0);
         check(retry_sw, (i < 3) ? 16'h63C2 - i : 16'h63C0);
      end
      u_host.verify(1'b1);
      check(wr_granted, 1'b0);
      session_end = 1'b1;
      @(posedge clk_i);
      #1;
      session_end = 1'b0;
      check(retry_sw, 16'h63C3);
      u_host.verify(1'b1);
      file_sel = npch_pkg::FILE_CC;
      @(posedge clk_i);
      @(posedge clk_i);
      #1;
      check(wr_granted, 1'b0);
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      failures = 0;
      total_checks = 0;
      cycles = 0;
      ce_i = 1'b1;
      rst_i = 1'b1;
      session_end = 1'b0;
      file_sel = npch_pkg::FILE_NDEF;
      pwd_rd_wr = 1'b0;
      eeprom_fail = 1'b0;
      repeat (16) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      t_reset();
      t_security();
      t_enable_disable();
      t_change();
      t_errors();
      t_retry();
      end_of_test();
   end
endmodule
